// *** inc/meb_defs.vh ***
// Purpose: constants for the multiplexed bus pin unit
// Assumes: byte-wide register port, 40 MHz clock
// Notes:   offsets are register indices within the relocatable block
`ifndef MEB_DEFS_VH
`define MEB_DEFS_VH
// ************************************************************
// register offsets
// ************************************************************
`define MEB_OFS_PORT_A      8'h00
`define MEB_OFS_PORT_B      8'h01
`define MEB_OFS_DIR_A       8'h02
`define MEB_OFS_DIR_B       8'h03
`define MEB_OFS_PORT_E      8'h08
`define MEB_OFS_DIR_E       8'h09
`define MEB_OFS_FUNC_E      8'h0a
`define MEB_OFS_MODE        8'h0b
`define MEB_OFS_PULL        8'h0c
`define MEB_OFS_DRIVE       8'h0d
`define MEB_OFS_BUS_CTL     8'h0e
`define MEB_OFS_IRQ_CTL     8'h1e
`define MEB_OFS_PORT_K      8'h32
`define MEB_OFS_DIR_K       8'h33
// ************************************************************
// field positions
// ************************************************************
`define MEB_FUNC_CLK_DIS    4
`define MEB_FUNC_STRB_EN    3
`define MEB_FUNC_RW_EN      2
`define MEB_MODE_VIS        3
`define MEB_MODE_EXPK       0
`define MEB_BUS_STRETCH     0
`define MEB_BUS_TAG_EN      1
`define MEB_BUS_XCS_EN      2
`define MEB_BUS_ECS_EN      3
`define MEB_IRQ_EDGE        7
`define MEB_IRQ_EN          6
// ************************************************************
// reset values, modes and stretch count
// ************************************************************
`define MEB_RST_ZERO        8'h00
`define MEB_RST_IRQ_CTL     8'h40
`define MEB_MD_SNGL         3'h0
`define MEB_MD_PERIPH       3'h2
`define MEB_MD_EMU_NARROW   3'h5
`define MEB_MD_EXP_WIDE     3'h7
`define MEB_STRETCH_CYC     2'h2
`endif

// *** design/meb_bus_pins.v ***
// Purpose: port e / port k pin functions and register map of the multiplexed bus unit
// Assumes: one clock clk_in, synchronous active-low reset, pins synchronised here
// Notes:   mode pins are captured on the first clock after reset release
//          pulse-mode bus clock is a small three-state machine
`include "meb_defs.vh"
module meb_bus_pins #(
  parameter [7:0] BASE_HI = 8'h00
) (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire [15:0] addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [7:0]  rdata_out,
  input  wire [2:0]  mode_pins_in,
  input  wire        access_in,
  input  wire        access_slow_in,
  input  wire        access_byte_in,
  input  wire        access_rd_in,
  input  wire [5:0]  access_addr_hi_in,
  input  wire        access_xdata_in,
  input  wire        access_emu_in,
  input  wire [7:0]  port_e_pin_in,
  output wire [7:0]  port_e_pin_out,
  output wire [7:0]  port_e_oe_out,
  input  wire [7:0]  port_k_pin_in,
  output wire [7:0]  port_k_pin_out,
  output wire [7:0]  port_k_oe_out,
  output wire        bus_timing_clock_out,
  output reg         low_tag_seen_out,
  output wire        transfer_size_8_out,
  output wire        ext_write_out,
  output wire        maskable_request_out,
  output wire        nonmaskable_request_out
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  reg [7:0] pe_s1_q;
  reg [7:0] pe_s2_q;
  reg [7:0] pk_s1_q;
  reg [7:0] pk_s2_q;
  reg [2:0] mp_s1_q;
  reg [2:0] mp_s2_q;
  always @(posedge clk_in) begin
    pe_s1_q <= port_e_pin_in;
    pe_s2_q <= pe_s1_q;
    pk_s1_q <= port_k_pin_in;
    pk_s2_q <= pk_s1_q;
    mp_s1_q <= mode_pins_in;
    mp_s2_q <= mp_s1_q;
  end
  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0] port_a_q;
  reg [7:0] port_b_q;
  reg [7:0] dir_a_q;
  reg [7:0] dir_b_q;
  reg [7:0] port_e_q;
  reg [7:0] dir_e_q;
  reg [7:0] func_e_q;
  reg [7:0] mode_q;
  reg [7:0] pull_q;
  reg [7:0] drive_q;
  reg [7:0] bus_ctl_q;
  reg [7:0] irq_ctl_q;
  reg [7:0] port_k_q;
  reg [7:0] dir_k_q;
  reg       mode_taken_q;
  wire [2:0] op_mode = mode_q[7:5];
  wire periph   = (op_mode == `MEB_MD_PERIPH);
  wire tag_mode = (op_mode == `MEB_MD_EXP_WIDE) || (op_mode == `MEB_MD_EMU_NARROW);
  wire expanded = op_mode[0];
  wire hit = (addr_in[15:8] == BASE_HI);
  wire [7:0] ofs = addr_in[7:0];
  // ************************************************************
  // write decode
  // ************************************************************
  wire wr_hit = wr_in && hit;
  wire we_port_a  = wr_hit && (ofs == `MEB_OFS_PORT_A);
  wire we_port_b  = wr_hit && (ofs == `MEB_OFS_PORT_B);
  wire we_dir_a   = wr_hit && (ofs == `MEB_OFS_DIR_A);
  wire we_dir_b   = wr_hit && (ofs == `MEB_OFS_DIR_B);
  wire we_port_e  = wr_hit && (ofs == `MEB_OFS_PORT_E);
  wire we_dir_e   = wr_hit && (ofs == `MEB_OFS_DIR_E);
  wire we_func_e  = wr_hit && (ofs == `MEB_OFS_FUNC_E);
  wire we_mode    = wr_hit && (ofs == `MEB_OFS_MODE);
  wire we_pull    = wr_hit && (ofs == `MEB_OFS_PULL);
  wire we_drive   = wr_hit && (ofs == `MEB_OFS_DRIVE);
  wire we_bus_ctl = wr_hit && (ofs == `MEB_OFS_BUS_CTL);
  wire we_irq_ctl = wr_hit && (ofs == `MEB_OFS_IRQ_CTL);
  wire we_port_k  = wr_hit && (ofs == `MEB_OFS_PORT_K);
  wire we_dir_k   = wr_hit && (ofs == `MEB_OFS_DIR_K);
  // reserved writes dropped: no strobe decodes them
  // ************************************************************
  // mode capture
  // ************************************************************
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      mode_taken_q <= 1'b0;
      mode_q       <= `MEB_RST_ZERO;
    end else begin
      // mode field taken once from the synchronised pins
      if (!mode_taken_q) begin
        mode_taken_q <= 1'b1;
        mode_q[7:5]  <= mp_s2_q;
      end
      if (we_mode) begin
        mode_q[4:0] <= wdata_in[4:0];
      end
    end
  end
  // ************************************************************
  // port a / b registers
  // ************************************************************
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      port_a_q <= `MEB_RST_ZERO;
      port_b_q <= `MEB_RST_ZERO;
      dir_a_q  <= `MEB_RST_ZERO;
      dir_b_q  <= `MEB_RST_ZERO;
    end else begin
      if (we_port_a) begin
        port_a_q <= wdata_in;
      end
      if (we_port_b) begin
        port_b_q <= wdata_in;
      end
      if (we_dir_a) begin
        dir_a_q <= wdata_in;
      end
      if (we_dir_b) begin
        dir_b_q <= wdata_in;
      end
    end
  end
  // ************************************************************
  // port e / k registers
  // ************************************************************
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      port_e_q <= `MEB_RST_ZERO;
      dir_e_q  <= `MEB_RST_ZERO;
      port_k_q <= `MEB_RST_ZERO;
      dir_k_q  <= `MEB_RST_ZERO;
    end else begin
      if (we_port_e) begin
        port_e_q <= wdata_in;
      end
      if (we_dir_e) begin
        dir_e_q <= {wdata_in[7:2], 2'b00};
      end
      if (we_port_k) begin
        port_k_q <= wdata_in;
      end
      if (we_dir_k) begin
        dir_k_q <= wdata_in;
      end
    end
  end
  // ************************************************************
  // control registers
  // ************************************************************
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      func_e_q  <= `MEB_RST_ZERO;
      pull_q    <= `MEB_RST_ZERO;
      drive_q   <= `MEB_RST_ZERO;
      bus_ctl_q <= `MEB_RST_ZERO;
      irq_ctl_q <= `MEB_RST_IRQ_CTL;
    end else begin
      if (we_func_e) begin
        func_e_q <= wdata_in;
      end
      if (we_pull) begin
        pull_q <= wdata_in;
      end
      if (we_drive) begin
        drive_q <= wdata_in;
      end
      if (we_bus_ctl) begin
        bus_ctl_q <= {4'h0, wdata_in[3:0]};
      end
      if (we_irq_ctl) begin
        irq_ctl_q <= {wdata_in[7:6], 6'h00};
      end
    end
  end
  // ************************************************************
  // bus timing clock
  // ************************************************************
  localparam [1:0] CK_IDLE = 2'h0;
  localparam [1:0] CK_LOW  = 2'h1;
  localparam [1:0] CK_HIGH = 2'h2;
  reg       bus_timing_clock_q;
  reg [1:0] str_q;
  reg [1:0] ck_state_q;
  wire clk_pin_en = expanded && !func_e_q[`MEB_FUNC_CLK_DIS];
  wire free_run   = !mode_q[`MEB_MODE_VIS] && !bus_ctl_q[`MEB_BUS_STRETCH];
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      bus_timing_clock_q     <= 1'b0;
      str_q      <= 2'h0;
      ck_state_q <= CK_IDLE;
    end else if (free_run) begin
      bus_timing_clock_q     <= ~bus_timing_clock_q;
      ck_state_q <= CK_IDLE;
    end else begin
      case (ck_state_q)
        CK_IDLE: begin
          bus_timing_clock_q <= 1'b0;
          if (access_in) begin
            ck_state_q <= CK_LOW;
            str_q      <= access_slow_in ? `MEB_STRETCH_CYC : 2'h0;
          end
        end
        CK_LOW: begin
          bus_timing_clock_q     <= 1'b1;
          ck_state_q <= CK_HIGH;
        end
        CK_HIGH: begin
          if (str_q != 2'h0) begin
            str_q <= str_q - 2'h1;
          end else begin
            bus_timing_clock_q     <= 1'b0;
            ck_state_q <= CK_IDLE;
          end
        end
        default: begin
          bus_timing_clock_q     <= 1'b0;
          ck_state_q <= CK_IDLE;
        end
      endcase
    end
  end
  assign bus_timing_clock_out = bus_timing_clock_q;
  // ************************************************************
  // tag sample, interrupts
  // ************************************************************
  reg bus_timing_clock_d1_q;
  reg irq_d1_q;
  reg irq_edge_q;
  wire strb_en = func_e_q[`MEB_FUNC_STRB_EN];
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      bus_timing_clock_d1_q        <= 1'b0;
      low_tag_seen_out <= 1'b0;
    end else begin
      bus_timing_clock_d1_q <= bus_timing_clock_q;
      if (bus_timing_clock_d1_q && !bus_timing_clock_q && tag_mode && strb_en && bus_ctl_q[`MEB_BUS_TAG_EN]) begin
        low_tag_seen_out <= !pe_s2_q[3];
      end
    end
  end
  // edge latch on the synchronised request pin
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_d1_q   <= 1'b1;
      irq_edge_q <= 1'b0;
    end else begin
      irq_d1_q <= pe_s2_q[1];
      if (irq_d1_q && !pe_s2_q[1]) begin
        irq_edge_q <= 1'b1;
      end else if (!irq_ctl_q[`MEB_IRQ_EDGE] || maskable_request_out) begin
        irq_edge_q <= 1'b0;
      end
    end
  end
  assign maskable_request_out = irq_ctl_q[`MEB_IRQ_EN] &&
    (irq_ctl_q[`MEB_IRQ_EDGE] ? irq_edge_q : !pe_s2_q[1]);
  assign nonmaskable_request_out = !pe_s2_q[0];
  assign transfer_size_8_out = periph && pe_s2_q[3];
  assign ext_write_out = periph && !pe_s2_q[2];
  // ************************************************************
  // port e / port k pins
  // ************************************************************
  reg [7:0] pe_fn_en;
  reg [7:0] pe_fn_val;
  always @* begin
    pe_fn_en  = 8'h00;
    pe_fn_val = 8'h00;
    pe_fn_en[4]  = clk_pin_en;
    pe_fn_val[4] = bus_timing_clock_q;
    pe_fn_en[3]  = expanded && strb_en && !periph;
    pe_fn_val[3] = !access_byte_in;
    pe_fn_en[2]  = expanded && func_e_q[`MEB_FUNC_RW_EN] && !periph;
    pe_fn_val[2] = access_rd_in;
  end
  wire [7:0] pe_gp_mask = ~pe_fn_en & 8'hfc;
  wire [7:0] pe_used = pe_fn_en | (periph ? 8'h0c : 8'h00);
  wire k_addr = expanded && mode_q[`MEB_MODE_EXPK];
  wire k_xcs  = expanded && bus_ctl_q[`MEB_BUS_XCS_EN];
  wire k_ecs  = expanded && bus_ctl_q[`MEB_BUS_ECS_EN];
  wire [7:0] pk_fn_en = {k_ecs, k_xcs, {6{k_addr}}};
  wire [7:0] pk_fn_val = {!(access_in && access_emu_in), !(access_in && access_xdata_in),
                          access_addr_hi_in};
  // ************************************************************
  // per-bit pin drivers
  // ************************************************************
  wire [7:0] pe_rd;
  wire [7:0] pk_rd;
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_pin
      assign port_e_oe_out[b]  = pe_fn_en[b] | (dir_e_q[b] & pe_gp_mask[b] & ~pe_used[b]);
      assign port_e_pin_out[b] = pe_fn_en[b] ? pe_fn_val[b] : port_e_q[b];
      assign port_k_oe_out[b]  = pk_fn_en[b] | dir_k_q[b];
      assign port_k_pin_out[b] = pk_fn_en[b] ? pk_fn_val[b] : port_k_q[b];
      assign pe_rd[b] = dir_e_q[b] ? port_e_q[b] : pe_s2_q[b];
      assign pk_rd[b] = dir_k_q[b] ? port_k_q[b] : pk_s2_q[b];
    end
  endgenerate
  // ************************************************************
  // read path
  // ************************************************************
  reg [7:0] rdata_d;
  always @* begin
    rdata_d = 8'h00;
    if (rd_in && hit) begin
      case (ofs)
        `MEB_OFS_PORT_A:  rdata_d = port_a_q;
        `MEB_OFS_PORT_B:  rdata_d = port_b_q;
        `MEB_OFS_DIR_A:   rdata_d = dir_a_q;
        `MEB_OFS_DIR_B:   rdata_d = dir_b_q;
        `MEB_OFS_PORT_E:  rdata_d = pe_rd;
        `MEB_OFS_DIR_E:   rdata_d = dir_e_q;
        `MEB_OFS_FUNC_E:  rdata_d = func_e_q;
        `MEB_OFS_MODE:    rdata_d = mode_q;
        `MEB_OFS_PULL:    rdata_d = pull_q;
        `MEB_OFS_DRIVE:   rdata_d = drive_q;
        `MEB_OFS_BUS_CTL: rdata_d = bus_ctl_q;
        `MEB_OFS_IRQ_CTL: rdata_d = irq_ctl_q;
        `MEB_OFS_PORT_K:  rdata_d = pk_rd;
        `MEB_OFS_DIR_K:   rdata_d = dir_k_q;
        default:          rdata_d = 8'h00;
      endcase
    end
  end
  // read data stands one cycle per read cycle, zero otherwise
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_d;
    end
  end
endmodule // meb_bus_pins

// *** tb/meb_bus_pins_sva.sv ***
// Purpose: port-level assertions of the bus pin unit
// Assumes: one clock domain, synchronous active-low reset
// Notes:   pin inputs reach the core through two sync flops
module meb_bus_pins_sva #(
  parameter [7:0] BASE_HI = 8'h00
) (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [15:0] addr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        access_slow_in,
  input wire logic [7:0]  port_e_pin_in,
  input wire logic [7:0]  port_e_oe_out,
  input wire logic        bus_timing_clock_out,
  input wire logic        transfer_size_8_out,
  input wire logic        ext_write_out,
  input wire logic        nonmaskable_request_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence slow_high;
    bus_timing_clock_out [*3] ##1 !bus_timing_clock_out;
  endsequence
  rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside its slot");
  rsvd_zero_a: assert property (rd_in && addr_in[7:0] inside {8'h04, 8'h07, 8'h20}
    |=> rdata_out == 8'h00) else $error("reserved read not zero");
  base_miss_a: assert property (rd_in && addr_in[15:8] != BASE_HI
    |=> rdata_out == 8'h00) else $error("foreign base answered");
  e_in_only_a: assert property (port_e_oe_out[1:0] == 2'b00)
    else $error("input-only pin driven");
  nmi_sync_a: assert property ($stable(port_e_pin_in[0]) [*2]
    |=> nonmaskable_request_out != $past(port_e_pin_in[0])) else $error("nmi level wrong");
  size_pin_a: assert property (transfer_size_8_out && $past(nrst_in, 2)
    |-> $past(port_e_pin_in[3], 2)) else $error("size flag without pin");
  rw_pin_a: assert property (ext_write_out && $past(nrst_in, 2)
    |-> !$past(port_e_pin_in[2], 2)) else $error("write flag without pin");
  clk_fast_a: assert property ($rose(bus_timing_clock_out) && !$past(access_slow_in, 2)
    |=> !bus_timing_clock_out) else $error("fast high phase wrong");
  clk_slow_a: assert property ($rose(bus_timing_clock_out) && $past(access_slow_in, 2)
    |-> slow_high) else $error("slow high phase wrong");
endmodule // meb_bus_pins_sva
bind meb_bus_pins meb_bus_pins_sva #(.BASE_HI(BASE_HI)) meb_bus_pins_sva_inst (.*);

// *** tb/meb_ext_model.sv ***
// Purpose: far-side pin levels around port k (high byte) and port e (low byte)
// Assumes: the far side always holds its pins at a defined level
// Notes:   in peripheral mode the far side plays the tester on e3 and e2
module meb_ext_model (
  input  wire logic [15:0] drv_in,
  input  wire logic [15:0] oe_in,
  input  wire logic [15:0] far_in,
  output wire logic [15:0] pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // driven pins win, else far level
  assign pin_out = (oe_in & drv_in) | (~oe_in & far_in);
endmodule // meb_ext_model

// *** tb/test_meb_bus_pins.sv ***
// Purpose: self-checking bench of the port e / port k bus pin unit
// Assumes: 40 MHz clock, register block at a nonzero base
// Notes:   each operating mode is entered through a fresh reset
module test_meb_bus_pins;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0]  base = 8'h12, wdata_in = 8'h00;
  logic [15:0] addr_in = 16'h0000, far = 16'h00ff;
  logic [2:0]  mode_pins_in = 3'h0;
  logic        access_in = 1'b0, access_slow_in = 1'b0, access_byte_in = 1'b0;
  logic        access_rd_in = 1'b0, access_xdata_in = 1'b0, access_emu_in = 1'b0;
  logic [5:0]  access_addr_hi_in = 6'h00;
  wire  [7:0]  rdata_out, port_e_pin_in, port_e_pin_out, port_e_oe_out;
  wire  [7:0]  port_k_pin_in, port_k_pin_out, port_k_oe_out;
  wire         bus_timing_clock_out, low_tag_seen_out, transfer_size_8_out;
  wire         ext_write_out, maskable_request_out, nonmaskable_request_out;
  int          fail_count = 0, comparisons = 0;
  always #12.5 clk_in = ~clk_in;
  meb_bus_pins #(.BASE_HI(8'h12)) meb_bus_pins_inst (.*);
  meb_ext_model meb_ext_model_inst (.drv_in({port_k_pin_out, port_e_pin_out}),
    .oe_in({port_k_oe_out, port_e_oe_out}), .far_in(far),
    .pin_out({port_k_pin_in, port_e_pin_in}));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= {base, a};
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= {base, a};
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  task automatic rst(input logic [2:0] m);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    mode_pins_in <= m;
    cyc(16);
    nrst_in <= 1'b1;
  endtask
  task automatic t_regs;
    logic [0:12][7:0] ofs;
    ofs = {8'h02, 8'h03, 8'h04, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
      8'h0f, 8'h20, 8'h32};
    for (int i = 0; i < 13; i++) begin
      rd(ofs[i], 8'h00);
    end
    rd(8'h1e, 8'h40);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'hff);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h00);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'hfc);
    wr(8'h1e, 8'hff);
    rd(8'h1e, 8'hc0);
    base = 8'h00;
    wr(8'h33, 8'hff);
    rd(8'h1e, 8'h00);
    base = 8'h12;
    rd(8'h33, 8'h00);
  endtask
  task automatic t_ports;
    wr(8'h33, 8'hf0);
    chk(port_k_oe_out, 8'hf0);
    wr(8'h32, 8'ha5);
    chk(port_k_pin_out & 8'hf0, 8'ha0);
    chk(port_e_oe_out, 8'hfc);
    wr(8'h08, 8'h54);
    @(posedge clk_in);
    far <= 16'h3c02;
    cyc(3);
    rd(8'h32, 8'hac);
    rd(8'h08, 8'h56);
    chk(8'(nonmaskable_request_out), 8'h01);
    @(posedge clk_in);
    far <= 16'h3c00;
    cyc(3);
    #1 chk(8'(maskable_request_out), 8'h01);
    rd(8'h08, 8'h54);
    chk(8'(maskable_request_out), 8'h00);
  endtask
  task automatic t_clk;
    logic v;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      #1 v = bus_timing_clock_out;
      @(posedge clk_in);
      #1 chk(8'(bus_timing_clock_out), 8'(!v));
    end
    wr(8'h0e, 8'h01);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_in);
      access_in <= 1'b1;
      access_slow_in <= s[0];
      @(posedge clk_in);
      access_in <= 1'b0;
      access_slow_in <= 1'b0;
      for (int c = 0; c < 5; c++) begin
        #1 chk(8'(bus_timing_clock_out), 8'(c >= 1 && c < 2 + 2 * s));
        @(posedge clk_in);
      end
    end
    wr(8'h0e, 8'h00);
    wr(8'h0b, 8'h08);
    cyc(1);
    #1 chk(8'(bus_timing_clock_out), 8'h00);
    cyc(1);
    #1 chk(8'(bus_timing_clock_out), 8'h00);
  endtask
  task automatic t_exp;
    cyc(2);
    #1 chk(8'({port_e_oe_out[4], port_e_pin_out[4]}), 8'({1'b1, bus_timing_clock_out}));
    wr(8'h0b, 8'h01);
    wr(8'h0e, 8'h0c);
    wr(8'h0a, 8'h1c);
    chk(8'(port_e_oe_out[4]), 8'h00);
    @(posedge clk_in);
    access_in <= 1'b1;
    access_addr_hi_in <= 6'h2b;
    access_xdata_in <= 1'b1;
    access_byte_in <= 1'b1;
    access_rd_in <= 1'b1;
    @(posedge clk_in);
    #1 chk(port_k_pin_out, 8'hab);
    chk(port_k_oe_out, 8'hff);
    chk(port_e_oe_out & 8'h0c, 8'h0c);
    chk(port_e_pin_out & 8'h0c, 8'h04);
    @(posedge clk_in);
    access_xdata_in <= 1'b0;
    access_emu_in <= 1'b1;
    @(posedge clk_in);
    #1 chk(port_k_pin_out, 8'h6b);
    @(posedge clk_in);
    access_in <= 1'b0;
    wr(8'h0e, 8'h0e);
    cyc(6);
    #1 chk(8'(low_tag_seen_out), 8'h01);
    @(posedge clk_in);
    access_byte_in <= 1'b0;
    cyc(6);
    #1 chk(8'(low_tag_seen_out), 8'h00);
  endtask
  task automatic t_periph;
    @(posedge clk_in);
    far <= 16'h00fb;
    cyc(3);
    #1 chk(8'({transfer_size_8_out, ext_write_out, port_e_oe_out[2]}), 8'h06);
    @(posedge clk_in);
    far <= 16'h00f7;
    cyc(3);
    #1 chk(8'({transfer_size_8_out, ext_write_out, port_e_oe_out[2]}), 8'h00);
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst(3'h0);
    t_regs;
    t_ports;
    t_clk;
    rst(3'h7);
    t_exp;
    rst(3'h2);
    t_periph;
    report_and_stop;
  end
  initial begin
    #100us;
    fail_count++;
    report_and_stop;
  end
endmodule // test_meb_bus_pins
